// File: rtl/hfp_pkg.sv
// Package: register map, field layout and states of the hybrid positioner
`default_nettype none
package hfp_pkg;
    // ------------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_TARGET = 8'h04;
    localparam logic [7:0] OFS_FINE_WIN = 8'h08;
    localparam logic [7:0] OFS_COARSE_OFFS = 8'h0c;
    localparam logic [7:0] OFS_COARSE_WIN = 8'h10;
    localparam logic [7:0] OFS_CORR_VEL = 8'h14;
    localparam logic [7:0] OFS_ZN_FACTOR = 8'h18;
    localparam logic [7:0] OFS_TIMEOUT_MS = 8'h1c;
    localparam logic [7:0] OFS_STATUS = 8'h20;
    localparam logic [7:0] OFS_POSITION = 8'h24;
    localparam int ADDR_W = 8;
    // ------------------------------------------------------------------
    // Control and status fields
    // ------------------------------------------------------------------
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_REL_BIT = 4;
    localparam int CTRL_GO_BIT = 8;
    localparam int CTRL_ABORT_BIT = 9;
    localparam int STAT_PHASE_LSB = 0;
    localparam int STAT_DONE_BIT = 16;
    localparam int STAT_TMO_BIT = 17;
    localparam int STAT_BAD_BIT = 18;
    localparam int STAT_BUSY_BIT = 19;
    localparam int STAT_MOFF_BIT = 20;
    // ------------------------------------------------------------------
    // Modes and reset values
    // ------------------------------------------------------------------
    localparam logic [3:0] MODE_LAST_PLAIN = 4'h5;
    localparam logic [3:0] MODE_STEP_HOLD = 4'h7;
    localparam logic [3:0] MODE_VEL = 4'h8;
    localparam logic [3:0] MODE_VEL_HOLD = 4'h9;
    localparam logic [31:0] RST_FINE_WIN = 32'h0000_0005;
    localparam logic [31:0] RST_COARSE_OFFS = 32'hffff_ffc0;
    localparam logic [31:0] RST_COARSE_WIN = 32'h0000_001e;
    localparam logic [31:0] RST_CORR_VEL = 32'h0001_0000;
    localparam logic [31:0] RST_ZN_FACTOR = 32'h0001_0000;
    localparam int ZN_FRAC_BITS = 16;
    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 25;
    localparam int MS_NS = 1000000;
    localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;
    // ------------------------------------------------------------------
    // Sequencer states
    // ------------------------------------------------------------------
    typedef enum logic [6:0] {
        ST_IDLE = 7'b000_0001,
        ST_ISSUE = 7'b000_0010,
        ST_MWAIT = 7'b000_0100,
        ST_VEL = 7'b000_1000,
        ST_VSTOP = 7'b001_0000,
        ST_FINE = 7'b010_0000,
        ST_HOLD = 7'b100_0000
    } hfp_state_e;
endpackage : hfp_pkg
`default_nettype wire

// File: rtl/hfp_positioner.sv
// Follow-up positioning sequencer for a stepper plus piezo hybrid stage
//
// Chosen here: the register offsets and the APB slave port.
`default_nettype none
// How it works
// - Modes 0-5 plain, 6-9 piezo assisted
// - Absolute target, or relative to position by control bit 4
// - Coarse move first, then correction, then piezo
// - Z/N scales deviation into motor travel
// - Coarse done inside offset target plus window
// - Outside coarse window starts correction phase
// - Correction velocity positive, used as speed
// - Modes 6/7 repeat coarse move from position
// - Step correction ends in window or when the error stops shrinking
// - Modes 8/9 velocity move until window
// - Overshoot restarts velocity move reversed
// - Piezo ends in fine window, on saturation phase 2
// - Modes 7/9 keep piezo correcting drift
// - Piezo saturation while holding re-enters phase 2
// - Millisecond timeout shuts motor off, 0 disables
module hfp_positioner #(
    parameter int MS_CYCLES = hfp_pkg::MS_CYCLES
) (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    // APB slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [hfp_pkg::ADDR_W-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // Servo cycle and measurement system
    input wire logic servo_tick_i,
    input wire logic signed [31:0] meas_pos_i,
    // Stepper driver
    output logic mot_move_o,
    output logic signed [31:0] mot_dist_o,
    output logic mot_vel_run_o,
    output logic signed [31:0] mot_vel_o,
    output logic mot_off_o,
    input wire logic mot_busy_i,
    // Piezo driver
    output logic piezo_en_o,
    output logic signed [31:0] piezo_target_o,
    input wire logic piezo_sat_i
);
    import hfp_pkg::*;
    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        hfp_state_e st;
        logic [3:0] mode;
        logic rel;
        logic signed [31:0] target;
        logic [31:0] fwin;
        logic signed [31:0] coffs;
        logic [31:0] cwin;
        logic [31:0] cvel;
        logic [31:0] zn;
        logic [31:0] tmo;
        logic signed [31:0] dest;
        logic [32:0] perr;
        logic first;
        logic seen_busy;
        logic signed [31:0] pos;
        logic done;
        logic tmo_f;
        logic bad;
        logic moff;
        logic mv;
        logic signed [31:0] mdist;
        logic vrun;
        logic vdir;
        logic pz;
        logic [31:0] prdata;
        logic [31:0] pres;
        logic [31:0] ms;
    } hfp_regs_s;
    hfp_regs_s q;
    hfp_regs_s d;
    logic rst_meta_q;
    logic rst_sync_q;
    // ------------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end
    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [32:0] abs_diff(input logic signed [31:0] a,
                                             input logic signed [31:0] b);
        logic signed [32:0] df;
        df = 33'(a) - 33'(b);
        return df[32] ? 33'(-df) : 33'(df);
    endfunction : abs_diff
    logic setup_rd;
    logic wr_en;
    logic steps_piezo;
    logic hold_mode;
    logic vel_mode;
    logic signed [31:0] cur_pos;
    logic signed [31:0] coarse_dest;
    logic [32:0] cerr;
    logic in_coarse;
    logic in_fine;
    logic toward;
    logic signed [63:0] travel;
    logic [3:0] phase;
    logic [31:0] status;
    assign setup_rd = psel_i && !penable_i && !pwrite_i;
    assign wr_en = psel_i && penable_i && pwrite_i;
    assign steps_piezo = q.mode > MODE_LAST_PLAIN;
    assign hold_mode = q.mode == MODE_STEP_HOLD || q.mode == MODE_VEL_HOLD;
    assign vel_mode = q.mode == MODE_VEL || q.mode == MODE_VEL_HOLD;
    // A tick decides on the sample it brings, not on the one before
    assign cur_pos = servo_tick_i ? meas_pos_i : q.pos;
    // Plain modes aim straight at the target with the fine window
    assign coarse_dest = steps_piezo ? q.dest + q.coffs : q.dest;
    assign cerr = abs_diff(cur_pos, coarse_dest);
    assign in_coarse = steps_piezo ? cerr <= {1'b0, q.cwin}
                                   : cerr <= {1'b0, q.fwin};
    assign in_fine = abs_diff(cur_pos, q.dest) <= {1'b0, q.fwin};
    assign toward = coarse_dest > cur_pos;
    assign travel = (64'(coarse_dest) - 64'(cur_pos)) * 64'(q.zn);
    assign phase = q.st == ST_IDLE ? 4'h0
                 : (q.st == ST_FINE || q.st == ST_HOLD) ? 4'h3
                 : (q.first && q.st inside {ST_ISSUE, ST_MWAIT}) ? 4'h1
                 : 4'h2;
    always_comb begin
        status = 32'h0;
        status[STAT_PHASE_LSB +: 4] = phase;
        status[STAT_DONE_BIT] = q.done;
        status[STAT_TMO_BIT] = q.tmo_f;
        status[STAT_BAD_BIT] = q.bad;
        status[STAT_BUSY_BIT] = q.st != ST_IDLE;
        status[STAT_MOFF_BIT] = q.moff;
    end
    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        d = q;
        d.mv = 1'b0;
        // Read data is latched in the setup cycle, so reads need no wait
        if (setup_rd) begin
            unique case (paddr_i)
                OFS_CTRL: d.prdata = {27'h0, q.rel, q.mode};
                OFS_TARGET: d.prdata = q.target;
                OFS_FINE_WIN: d.prdata = q.fwin;
                OFS_COARSE_OFFS: d.prdata = q.coffs;
                OFS_COARSE_WIN: d.prdata = q.cwin;
                OFS_CORR_VEL: d.prdata = q.cvel;
                OFS_ZN_FACTOR: d.prdata = q.zn;
                OFS_TIMEOUT_MS: d.prdata = q.tmo;
                OFS_STATUS: d.prdata = status;
                OFS_POSITION: d.prdata = q.pos;
                default: d.prdata = 32'h0;
            endcase
        end
        if (wr_en) begin
            unique case (paddr_i)
                OFS_CTRL: begin
                    d.mode = pwdata_i[CTRL_MODE_LSB +: 4];
                    d.rel = pwdata_i[CTRL_REL_BIT];
                end
                OFS_TARGET: d.target = pwdata_i;
                OFS_FINE_WIN: d.fwin = pwdata_i;
                OFS_COARSE_OFFS: d.coffs = pwdata_i;
                OFS_COARSE_WIN: d.cwin = pwdata_i;
                OFS_CORR_VEL: d.cvel = pwdata_i;
                OFS_ZN_FACTOR: d.zn = pwdata_i;
                OFS_TIMEOUT_MS: d.tmo = pwdata_i;
                default: ;
            endcase
        end
        d.pos = cur_pos;
        d.seen_busy = q.seen_busy || mot_busy_i;
        unique case (q.st)
            ST_IDLE: begin
                if (wr_en && paddr_i == OFS_CTRL
                        && pwdata_i[CTRL_GO_BIT]) begin
                    d.done = 1'b0;
                    d.tmo_f = 1'b0;
                    d.moff = 1'b0;
                    d.pres = 32'h0;
                    d.ms = 32'h0;
                    d.bad = pwdata_i[CTRL_MODE_LSB +: 4] > MODE_VEL_HOLD;
                    d.dest = pwdata_i[CTRL_REL_BIT] ? q.pos + q.target
                                                    : q.target;
                    d.first = 1'b1;
                    d.perr = '1;
                    if (pwdata_i[CTRL_MODE_LSB +: 4] <= MODE_VEL_HOLD) begin
                        d.st = ST_ISSUE;
                    end
                end
            end
            ST_ISSUE: begin
                if (servo_tick_i) begin
                    d.mv = 1'b1;
                    d.mdist = travel[ZN_FRAC_BITS +: 32];
                    d.seen_busy = 1'b0;
                    d.st = ST_MWAIT;
                end
            end
            ST_MWAIT: begin
                if (servo_tick_i && q.seen_busy && !mot_busy_i) begin
                    d.first = 1'b0;
                    d.perr = cerr;
                    if (in_coarse) begin
                        d.st = steps_piezo ? ST_FINE : ST_IDLE;
                        d.done = !steps_piezo;
                    end else if (vel_mode) begin
                        d.st = ST_VEL;
                    end else if (!q.first && cerr >= q.perr) begin
                        // Correction no longer shrinks the error: hand over as it stands
                        d.st = steps_piezo ? ST_FINE : ST_IDLE;
                        d.done = !steps_piezo;
                    end else begin
                        d.st = ST_ISSUE;
                    end
                end
            end
            ST_VEL: begin
                if (servo_tick_i) begin
                    if (in_coarse) begin
                        d.vrun = 1'b0;
                        d.st = ST_VSTOP;
                    end else if (!q.vrun || q.vdir != toward) begin
                        d.vrun = 1'b1;
                        d.vdir = toward;
                    end
                end
            end
            ST_VSTOP: begin
                if (servo_tick_i && !mot_busy_i) begin
                    d.st = in_coarse ? ST_FINE : ST_VEL;
                end
            end
            ST_FINE: begin
                d.pz = 1'b1;
                if (servo_tick_i) begin
                    if (in_fine) begin
                        d.done = 1'b1;
                        d.st = hold_mode ? ST_HOLD : ST_IDLE;
                        d.pz = hold_mode;
                    end else if (piezo_sat_i) begin
                        d.pz = 1'b0;
                        d.perr = '1;
                        d.st = vel_mode ? ST_VEL : ST_ISSUE;
                    end
                end
            end
            ST_HOLD: begin
                d.pz = 1'b1;
                if (servo_tick_i && piezo_sat_i) begin
                    d.done = 1'b0;
                    d.pz = 1'b0;
                    d.perr = '1;
                    d.pres = 32'h0;
                    d.ms = 32'h0;
                    d.st = vel_mode ? ST_VEL : ST_ISSUE;
                end
            end
        endcase
        // Timeout covers the moving phases only; holding may last forever
        if (q.st != ST_IDLE && q.st != ST_HOLD && q.tmo != 32'h0) begin
            if (q.pres == 32'(MS_CYCLES - 1)) begin
                d.pres = 32'h0;
                d.ms = q.ms + 32'h1;
            end else begin
                d.pres = q.pres + 32'h1;
            end
            if (q.ms >= q.tmo) begin
                d.moff = 1'b1;
                d.mv = 1'b0;
                d.tmo_f = 1'b1;
                d.vrun = 1'b0;
                d.pz = 1'b0;
                d.st = ST_IDLE;
            end
        end
        if (wr_en && paddr_i == OFS_CTRL && pwdata_i[CTRL_ABORT_BIT]) begin
            d.vrun = 1'b0;
            d.pz = 1'b0;
            d.st = ST_IDLE;
        end
        if (d.st == ST_IDLE) begin
            d.vrun = 1'b0;
        end
    end
    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            q <= '0;
            q.st <= ST_IDLE;
            q.fwin <= RST_FINE_WIN;
            q.coffs <= RST_COARSE_OFFS;
            q.cwin <= RST_COARSE_WIN;
            q.cvel <= RST_CORR_VEL;
            q.zn <= RST_ZN_FACTOR;
            q.perr <= '1;
        end else begin
            q <= d;
        end
    end
    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign prdata_o = q.prdata;
    assign pready_o = psel_i && penable_i;
    assign pslverr_o = psel_i && penable_i && paddr_i > OFS_POSITION;
    assign mot_move_o = q.mv;
    assign mot_dist_o = q.mdist;
    assign mot_vel_run_o = q.vrun;
    // Speed magnitude comes from the register, direction from the error
    assign mot_vel_o = q.vdir ? q.cvel : -q.cvel;
    assign mot_off_o = q.moff;
    assign piezo_en_o = q.pz;
    assign piezo_target_o = q.dest;
endmodule : hfp_positioner
`default_nettype wire

// File: verification/hfp_positioner_asserts.sv
// Checker: port properties of the positioner
`default_nettype none
module hfp_positioner_asserts #(
    parameter int MS_CYCLES = 4
) (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    // APB
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic [hfp_pkg::ADDR_W-1:0] paddr_i,
    input wire logic pready_o,
    input wire logic pslverr_o,
    // Motion
    input wire logic servo_tick_i,
    input wire logic mot_move_o,
    input wire logic signed [31:0] mot_dist_o,
    input wire logic mot_vel_run_o,
    input wire logic signed [31:0] mot_vel_o,
    input wire logic mot_off_o,
    input wire logic piezo_en_o
);
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!rst_n_i);
    a_apb_ready: assert property (psel_i && penable_i |-> pready_o)
        else $error("no zero wait answer");
    a_apb_map: assert property (psel_i && penable_i
        |-> pslverr_o == (paddr_i > 8'h24)) else $error("bad slverr");
    a_move_tick: assert property ($rose(mot_move_o)
        |-> $past(servo_tick_i) || $past(servo_tick_i, 2))
        else $error("move off tick");
    a_move_pulse: assert property (mot_move_o |=> !mot_move_o)
        else $error("move pulse too long");
    a_dist_held: assert property (mot_move_o
        |=> $stable(mot_dist_o)[*2]) else $error("distance not held");
    a_off_quiet: assert property (mot_off_o
        |-> !mot_vel_run_o && !mot_move_o && !piezo_en_o)
        else $error("drive on after shut off");
    a_vel_speed: assert property (mot_vel_run_o |-> mot_vel_o != 0)
        else $error("zero correction speed");
    a_piezo_tick: assert property ($rose(piezo_en_o)
        |-> $past(servo_tick_i) || $past(servo_tick_i, 2))
        else $error("piezo start off tick");
    a_piezo_last: assert property ($rose(piezo_en_o)
        |-> !mot_vel_run_o && !mot_move_o) else $error("piezo with motor");
    a_one_move: assert property (mot_move_o |-> !mot_vel_run_o)
        else $error("two motor moves");
endmodule : hfp_positioner_asserts
bind hfp_positioner hfp_positioner_asserts #(.MS_CYCLES(MS_CYCLES)) u_chk (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i),
    .penable_i(penable_i), .paddr_i(paddr_i), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .servo_tick_i(servo_tick_i),
    .mot_move_o(mot_move_o), .mot_dist_o(mot_dist_o),
    .mot_vel_run_o(mot_vel_run_o), .mot_vel_o(mot_vel_o),
    .mot_off_o(mot_off_o), .piezo_en_o(piezo_en_o));
`default_nettype wire

// File: verification/hfp_stage_model.sv
// Stage model: stepper, piezo and measurement system
`default_nettype none
module hfp_stage_model (
    // Clock
    input wire logic core_clk_i,
    // Commands from the positioner
    input wire logic mot_move_i,
    input wire logic signed [31:0] mot_dist_i,
    input wire logic mot_vel_run_i,
    input wire logic signed [31:0] mot_vel_i,
    input wire logic piezo_en_i,
    input wire logic signed [31:0] piezo_target_i,
    // Faults ordered by the bench
    input wire logic signed [31:0] slip_i,
    input wire logic signed [31:0] busy_len_i,
    input wire logic signed [31:0] piezo_rng_i,
    // Feedback
    output logic mot_busy_o,
    output logic signed [31:0] meas_pos_o,
    output logic piezo_sat_o
);
    timeunit 1ns;
    timeprecision 100ps;
    int mot_pos = 0;
    int cnt = 0;
    int err;
    // Step moves land off by slip, only when a test asks for it
    always @(posedge core_clk_i) begin
        if (mot_move_i) begin
            mot_pos <= mot_pos + mot_dist_i + slip_i;
            cnt <= busy_len_i;
        end else if (cnt > 0) begin
            cnt <= cnt - 1;
        end
        if (mot_vel_run_i) begin
            mot_pos <= mot_pos + (mot_vel_i >>> 16);
        end
    end
    assign err = piezo_target_i - mot_pos;
    assign mot_busy_o = (cnt > 0) || mot_vel_run_i;
    // Limited stroke: beyond it the piezo gives up
    assign piezo_sat_o = piezo_en_i
        && (err > piezo_rng_i || err < -piezo_rng_i);
    assign meas_pos_o = (piezo_en_i && !piezo_sat_o) ? piezo_target_i
        : mot_pos;
endmodule : hfp_stage_model
`default_nettype wire

// File: verification/hfp_positioner_tb_top.sv
// Testbench: positioner against bench model and stage model
`default_nettype none
module hfp_positioner_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import hfp_pkg::*;
    logic clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, tick = 0;
    logic [7:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic pready, pslverr, mmove, mvrun, moff, mbusy, pz_en, psat, err;
    logic signed [31:0] meas, mdist, mvel, ptgt, slip = 0;
    int busy_len = 3, pz_rng = 200, bad_count = 0, n_tests = 0;
    int seed = 47851, cyc = 0, vneg = 0;
    longint pos = 0, dst, d;
    logic [31:0] q[$];
    logic [7:0] ra[7] = '{OFS_FINE_WIN, OFS_COARSE_OFFS, OFS_COARSE_WIN,
        OFS_CORR_VEL, OFS_ZN_FACTOR, OFS_TIMEOUT_MS, OFS_STATUS};
    logic [31:0] rv[7] = '{RST_FINE_WIN, RST_COARSE_OFFS, RST_COARSE_WIN,
        RST_CORR_VEL, RST_ZN_FACTOR, 32'h0, 32'h0};
    hfp_positioner #(.MS_CYCLES(4)) DUT (.core_clk_i(clk), .rst_n_i(rst_n),
        .psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr),
        .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
        .pslverr_o(pslverr), .servo_tick_i(tick), .meas_pos_i(meas),
        .mot_move_o(mmove), .mot_dist_o(mdist), .mot_vel_run_o(mvrun),
        .mot_vel_o(mvel), .mot_off_o(moff), .mot_busy_i(mbusy),
        .piezo_en_o(pz_en), .piezo_target_o(ptgt), .piezo_sat_i(psat));
    hfp_stage_model u_stage (.core_clk_i(clk), .mot_move_i(mmove),
        .mot_dist_i(mdist), .mot_vel_run_i(mvrun), .mot_vel_i(mvel),
        .piezo_en_i(pz_en), .piezo_target_i(ptgt), .slip_i(slip),
        .busy_len_i(busy_len), .piezo_rng_i(pz_rng), .mot_busy_o(mbusy),
        .meas_pos_o(meas), .piezo_sat_o(psat));
    initial forever #12.5 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        tick <= (cyc % 8) == 7;
        if (cyc > 60000) begin
            bad_count++;
            $display("[FAIL] %0t run too long", $time);
            give_verdict();
        end
    end
    always @(negedge clk) begin
        if (mmove) q.push_back(mdist);
        if (mvrun && mvel < 0) vneg++;
    end
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : give_verdict
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %0t got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] wd);
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask : apb
    task automatic go(input logic [3:0] m, input logic rel);
        repeat (16) @(posedge clk);
        q.delete();
        apb(1'b1, OFS_CTRL, {23'h0, 1'b1, 3'h0, rel, m});
    endtask : go
    task automatic wait_bit(input int b, input logic v);
        rd = {32{~v}};
        for (int i = 0; i < 400 && rd[b] !== v; i++) begin
            apb(1'b0, OFS_STATUS, 0);
        end
        if (rd[b] !== v) begin
            bad_count++;
            $display("[FAIL] %0t status bit %0d never settled", $time, b);
        end
    endtask : wait_bit
    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        foreach (ra[i]) begin
            apb(1'b0, ra[i], 0);
            chk(rd, rv[i]);
        end
        apb(1'b0, 8'h28, 0);
        chk(rd, 32'h0);
        chk({31'h0, err}, 32'h1);
        $display("test reset done");
        dst = 500 + $unsigned($random(seed)) % 1000;
        apb(1'b1, OFS_TARGET, dst[31:0]);
        apb(1'b1, OFS_ZN_FACTOR, 32'h0000_8000);
        go(4'h6, 1'b0);
        wait_bit(STAT_DONE_BIT, 1'b1);
        chk(rd[STAT_DONE_BIT+1:STAT_DONE_BIT], 2'b01);
        do begin
            d = ((dst - 64 - pos) * 32768) >>> 16;
            chk(q.pop_front(), d[31:0]);
            pos += d;
        end while (dst - 64 - pos > 30);
        chk(q.size(), 0);
        chk(ptgt, dst[31:0]);
        $display("test step modes done");
        apb(1'b1, OFS_ZN_FACTOR, RST_ZN_FACTOR);
        for (int m = 0; m <= 5; m++) begin
            d = 50 + $unsigned($random(seed)) % 250;
            if (m[0]) d = -d;
            apb(1'b1, OFS_TARGET, d[31:0]);
            go(m[3:0], 1'b1);
            wait_bit(STAT_DONE_BIT, 1'b1);
            chk(q.pop_front(), d[31:0]);
            pos += d;
        end
        go(4'ha, 1'b0);
        apb(1'b0, OFS_STATUS, 0);
        chk(rd[STAT_BAD_BIT], 1'b1);
        $display("test plain modes done");
        slip <= 100;
        dst = pos + 400;
        vneg = 0;
        apb(1'b1, OFS_TARGET, dst[31:0]);
        go(MODE_VEL, 1'b0);
        wait_bit(STAT_DONE_BIT, 1'b1);
        chk(q.pop_front(), dst - 64 - pos);
        chk(vneg > 0 && q.size() == 0, 1'b1);
        slip <= 0;
        $display("test velocity mode done");
        go(MODE_VEL_HOLD, 1'b0);
        wait_bit(STAT_DONE_BIT, 1'b1);
        repeat (40) @(posedge clk);
        chk(pz_en, 1'b1);
        pz_rng <= 0;
        wait_bit(STAT_DONE_BIT, 1'b0);
        chk(rd[STAT_DONE_BIT], 1'b0);
        apb(1'b1, OFS_CTRL, 32'h0000_0200);
        pz_rng <= 200;
        $display("test hold mode done");
        busy_len <= 400;
        apb(1'b1, OFS_TIMEOUT_MS, 32'h1);
        go(4'h6, 1'b0);
        wait_bit(STAT_TMO_BIT, 1'b1);
        chk({rd[STAT_TMO_BIT], moff}, 2'b11);
        $display("test timeout done");
        give_verdict();
    end
endmodule : hfp_positioner_tb_top
`default_nettype wire
